/* search_engine_consts.svh */
// constants of the search engine register bank: indices, layouts, resets
`ifndef SEARCH_ENGINE_CONSTS_SVH
`define SEARCH_ENGINE_CONSTS_SVH

`define REG_WIDTH        68
`define HI_WIDTH         36
`define ADDR_WIDTH       12
// register indices; byte address is four times the index
`define COMP_BASE_IDX    6'h00
`define MASK_BASE_IDX    6'h20
`define HIT_BASE_IDX     6'h30
`define CONTROL_IDX      6'h38
`define DEVICE_INFORMATION_IDX         6'h39
`define BURST_RD_IDX     6'h3a
`define BURST_WR_IDX     6'h3b
`define NEXT_FREE_IDX    6'h3c
// upper-bit staging windows (byte addresses)
`define HI_LOW_ADDR      12'h100
`define HI_TOP_ADDR      12'h104
// hit index register layout
`define HIT_INDEX_MSB    13
`define HIT_VALID_BIT    31
// control register fields and reset
`define CTRL_ENABLE_BIT  1
`define CONTROL_RESET    68'h0_0000_0000_0000_0004
`define BURST_RESET      68'h0_0000_0000_0000_0000
`define DEVICE_INFORMATION_DEFAULT     68'h0_0000_0000_0000_0000
// axi response codes
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

/* search_engine_pkg.sv */
// types shared by the search engine register bank
`default_nettype none
package search_engine_pkg;

  typedef enum logic [1:0] {
    WIDTH_68,
    WIDTH_136,
    WIDTH_272
  } entry_width_t;

  // one cycle of a two-cycle search command
  typedef struct packed {
    logic        valid;
    logic        cycle_b;
    logic [3:0]  comp_pair;
    logic [2:0]  mask_pair;
    logic [67:0] key;
    logic [67:0] entry;
  } search_cmd_t;

  // outcome of a search, naming the hit slot given in cycle b
  typedef struct packed {
    logic         valid;
    logic [2:0]   hit_slot;
    logic         local_win;
    logic         global_win;
    entry_width_t width;
    logic [13:0]  index;
  } search_res_t;

  // masked array write
  typedef struct packed {
    logic        valid;
    logic [2:0]  mask_pair;
    logic        half;
    logic [67:0] old_word;
    logic [67:0] new_word;
  } array_wr_t;

endpackage
`default_nettype wire

/* search_engine_register_bank.sv */
// register bank of the search engine with an axi4-lite slave
`default_nettype none
`include "search_engine_consts.svh"

// Function
// - derive core clock from double-rate clock, phase
// - every register is 68 bits wide
// - indices 0-31 comparands, read only
// - indices 48-55 hit index, read only
// - control, device_information, burst, next-free at 56-60
// - indices 61-63 reserved, no register
// - cycle a to even, cycle b odd
// - comparands kept until overwritten, for learn
// - three-bit index picks mask pair 2n,2n+1
// - search mask 1 compares, 0 forces match
// - write mask 1 writes, 0 keeps bit
// - cycle b names the hit index register
// - indirect access only when valid flag set
// - 14-bit index, changes only on hit
// - index lsbs zero for wide partitions
// - index updates on local or global win
// - valid bit resets zero, set by global winner
module search_engine_register_bank #(
  parameter logic [67:0] DEVICE_INFORMATION_VALUE = `DEVICE_INFORMATION_DEFAULT // arbitrary identity value
) (
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          reset_i,
  input  wire logic                          phase_select_n_i,
  output logic                               core_clk_o,
  // axi4-lite write address and data
  input  wire logic                          awvalid_i,
  output logic                               awready_o,
  input  wire logic [`ADDR_WIDTH-1:0]        awaddr_i,
  input  wire logic                          wvalid_i,
  output logic                               wready_o,
  input  wire logic [31:0]                   wdata_i,
  input  wire logic [3:0]                    wstrb_i,
  // axi4-lite write response
  output logic                               bvalid_o,
  input  wire logic                          bready_i,
  output logic [1:0]                         bresp_o,
  // axi4-lite read
  input  wire logic                          arvalid_i,
  output logic                               arready_o,
  input  wire logic [`ADDR_WIDTH-1:0]        araddr_i,
  output logic                               rvalid_o,
  input  wire logic                          rready_i,
  output logic [31:0]                        rdata_o,
  output logic [1:0]                         rresp_o,
  // search datapath
  input  wire search_engine_pkg::search_cmd_t search_i,
  input  wire search_engine_pkg::search_res_t result_i,
  output logic [`REG_WIDTH-1:0]              bit_match_o,
  // masked array write
  input  wire search_engine_pkg::array_wr_t  array_wr_i,
  output logic [`REG_WIDTH-1:0]              array_merged_o,
  // learn and indirect access
  input  wire logic [3:0]                    learn_pair_i,
  output logic [`REG_WIDTH-1:0]              learn_even_o,
  output logic [`REG_WIDTH-1:0]              learn_odd_o,
  input  wire logic                          indirect_req_i,
  input  wire logic [2:0]                    indirect_slot_i,
  output logic                               indirect_go_o,
  output logic [13:0]                        indirect_index_o,
  // miscellany
  input  wire logic [`REG_WIDTH-1:0]         next_free_i,
  output logic [`REG_WIDTH-1:0]              control_o
);

  logic [`REG_WIDTH-1:0]  comp_reg [32];
  logic [`REG_WIDTH-1:0]  mask_reg [16];
  logic [13:0]            hit_index_reg [8];
  logic [7:0]             hit_valid_reg;
  logic [`REG_WIDTH-1:0]  control_reg;
  logic [`REG_WIDTH-1:0]  burst_rd_reg;
  logic [`REG_WIDTH-1:0]  burst_wr_reg;
  logic                   core_clk_reg;
  logic                   core_edge;

  logic                   aw_held_reg;
  logic                   w_held_reg;
  logic [`ADDR_WIDTH-1:0] aw_addr_reg;
  logic [31:0]            w_data_reg;
  logic [3:0]             w_strb_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   rvalid_reg;
  logic [31:0]            rdata_reg;
  logic [1:0]             rresp_reg;
  logic [`HI_WIDTH-1:0]   wr_hi_reg;
  logic [`HI_WIDTH-1:0]   rd_hi_reg;

  logic                   do_write;
  logic [5:0]             wr_idx;
  logic                   wr_is_hi;
  logic                   wr_in_map;
  logic [`REG_WIDTH-1:0]  wr_word;
  logic [`REG_WIDTH-1:0]  rd_word;
  logic [5:0]             rd_idx;
  logic                   rd_is_hi;
  logic                   rd_in_map;
  logic [`REG_WIDTH-1:0]  sel_mask;

  // byte-lane merge of a 32-bit write into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction

  // half-rate core clock; a low phase input realigns it
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      core_clk_reg <= 1'b0;
    end else if (!phase_select_n_i) begin
      core_clk_reg <= 1'b0;
    end else begin
      core_clk_reg <= ~core_clk_reg;
    end
  end

  // core-domain work happens on the double-rate edge ending a low phase
  assign core_edge  = ~core_clk_reg & phase_select_n_i;
  assign core_clk_o = core_clk_reg;

  // ---------------- axi write path ----------------
  assign awready_o = ~aw_held_reg;
  assign wready_o  = ~w_held_reg;
  assign bvalid_o  = bvalid_reg;
  assign bresp_o   = bresp_reg;
  assign do_write  = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_idx    = aw_addr_reg[7:2];
  assign wr_is_hi  = (aw_addr_reg == `HI_LOW_ADDR) ||
                     (aw_addr_reg == `HI_TOP_ADDR);
  assign wr_in_map = (aw_addr_reg[`ADDR_WIDTH-1:8] == '0) || wr_is_hi;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (awvalid_i && !aw_held_reg) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= awaddr_i;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (wvalid_i && !w_held_reg) begin
      w_held_reg <= 1'b1;
      w_data_reg <= wdata_i;
      w_strb_reg <= wstrb_i;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_in_map ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  // upper 36 bits are staged here and committed by the low-word write
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_hi_reg <= '0;
    end else if (do_write && aw_addr_reg == `HI_LOW_ADDR) begin
      wr_hi_reg[31:0] <= lane_merge(wr_hi_reg[31:0], w_data_reg, w_strb_reg);
    end else if (do_write && aw_addr_reg == `HI_TOP_ADDR &&
                 w_strb_reg[0]) begin
      wr_hi_reg[35:32] <= w_data_reg[3:0];
    end
  end

  // full 68-bit word committed by a low-word write
  always_comb begin
    wr_word = {wr_hi_reg, w_data_reg};
    unique case (wr_idx[5:4])
      2'b10:   wr_word[31:0] = lane_merge(mask_reg[wr_idx[3:0]][31:0],
                                          w_data_reg, w_strb_reg);
      default: wr_word[31:0] = lane_merge(control_reg[31:0] & {32{
                                 wr_idx == `CONTROL_IDX}} |
                                 burst_rd_reg[31:0] & {32{
                                 wr_idx == `BURST_RD_IDX}} |
                                 burst_wr_reg[31:0] & {32{
                                 wr_idx == `BURST_WR_IDX}},
                                 w_data_reg, w_strb_reg);
    endcase
  end

  // global masks: host writes only, no hardware source
  always_ff @(posedge clk_i) begin
    if (do_write && wr_in_map && !wr_is_hi &&
        wr_idx[5:4] == `MASK_BASE_IDX >> 4) begin
      mask_reg[wr_idx[3:0]] <= wr_word;
    end
  end

  // control and burst pointers; reserved and read-only indices ignore writes
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      control_reg  <= `CONTROL_RESET;
      burst_rd_reg <= `BURST_RESET;
      burst_wr_reg <= `BURST_RESET;
    end else if (do_write && wr_in_map && !wr_is_hi) begin
      unique case (wr_idx)
        `CONTROL_IDX:  control_reg  <= wr_word;
        `BURST_RD_IDX: burst_rd_reg <= wr_word;
        `BURST_WR_IDX: burst_wr_reg <= wr_word;
        default: ;
      endcase
    end
  end

  assign control_o = control_reg;

  // ---------------- axi read path ----------------
  assign arready_o = ~rvalid_reg;
  assign rvalid_o  = rvalid_reg;
  assign rdata_o   = rdata_reg;
  assign rresp_o   = rresp_reg;
  assign rd_idx    = araddr_i[7:2];
  assign rd_is_hi  = (araddr_i == `HI_LOW_ADDR) ||
                     (araddr_i == `HI_TOP_ADDR);
  assign rd_in_map = (araddr_i[`ADDR_WIDTH-1:8] == '0) || rd_is_hi;

  always_comb begin
    rd_word = '0;
    if (rd_idx < `MASK_BASE_IDX) begin
      rd_word = comp_reg[rd_idx[4:0]];
    end else if (rd_idx < `HIT_BASE_IDX) begin
      rd_word = mask_reg[rd_idx[3:0]];
    end else if (rd_idx < `CONTROL_IDX) begin
      rd_word[`HIT_INDEX_MSB:0] = hit_index_reg[rd_idx[2:0]];
      rd_word[`HIT_VALID_BIT]   = hit_valid_reg[rd_idx[2:0]];
    end else begin
      unique case (rd_idx)
        `CONTROL_IDX:   rd_word = control_reg;
        `DEVICE_INFORMATION_IDX:      rd_word = DEVICE_INFORMATION_VALUE;
        `BURST_RD_IDX:  rd_word = burst_rd_reg;
        `BURST_WR_IDX:  rd_word = burst_wr_reg;
        `NEXT_FREE_IDX: rd_word = next_free_i;
        default:        rd_word = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= `RESP_OKAY;
    end else if (arvalid_i && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_in_map ? `RESP_OKAY : `RESP_SLVERR;
      if (araddr_i == `HI_LOW_ADDR) begin
        rdata_reg <= rd_hi_reg[31:0];
      end else if (araddr_i == `HI_TOP_ADDR) begin
        rdata_reg <= {28'h000_0000, rd_hi_reg[35:32]};
      end else if (rd_in_map) begin
        rdata_reg <= rd_word[31:0];
      end else begin
        rdata_reg <= '0;
      end
    end else if (rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  // a low-word read snapshots the upper bits for the staging window
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_hi_reg <= '0;
    end else if (arvalid_i && !rvalid_reg && rd_in_map && !rd_is_hi) begin
      rd_hi_reg <= rd_word[`REG_WIDTH-1:32];
    end
  end

  // ---------------- search datapath ----------------
  assign sel_mask = mask_reg[{search_i.mask_pair, search_i.cycle_b}];

  // comparands are written only by searches and held until a later search writes the same pair and cycle
  always_ff @(posedge clk_i) begin
    if (core_edge && search_i.valid) begin
      comp_reg[{search_i.comp_pair, search_i.cycle_b}] <=
        search_i.key;
    end
  end

  // a one in the mask compares the bit, a zero forces a match
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bit_match_o <= '0;
    end else if (core_edge && search_i.valid) begin
      bit_match_o <= ~((search_i.key ^ search_i.entry) & sel_mask);
    end
  end

  // masked array write: ones take the new bit, zeros keep the old one
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      array_merged_o <= '0;
    end else if (core_edge && array_wr_i.valid) begin
      array_merged_o <=
        (array_wr_i.new_word &
         mask_reg[{array_wr_i.mask_pair, array_wr_i.half}]) |
        (array_wr_i.old_word &
         ~mask_reg[{array_wr_i.mask_pair, array_wr_i.half}]);
    end
  end

  // hit index registers, one per slot
  for (genvar s = 0; s < 8; s++) begin : g_hit
    logic take;
    assign take = core_edge && result_i.valid &&
                  result_i.hit_slot == 3'(s);

    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        hit_index_reg[s] <= '0;
      end else if (take && (result_i.local_win || result_i.global_win)) begin
        unique case (result_i.width)
          search_engine_pkg::WIDTH_136:
            hit_index_reg[s] <= {result_i.index[13:1], 1'b0};
          search_engine_pkg::WIDTH_272:
            hit_index_reg[s] <= {result_i.index[13:2], 2'b00};
          default:
            hit_index_reg[s] <= result_i.index;
        endcase
      end
    end

    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        hit_valid_reg[s] <= 1'b0;
      end else if (take && result_i.global_win) begin
        hit_valid_reg[s] <= 1'b1;
      end
    end
  end

  // ---------------- learn and indirect access ----------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      learn_even_o <= '0;
      learn_odd_o  <= '0;
    end else begin
      learn_even_o <= comp_reg[{learn_pair_i, 1'b0}];
      learn_odd_o  <= comp_reg[{learn_pair_i, 1'b1}];
    end
  end

  // only the device holding a valid hit carries out the access
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      indirect_go_o    <= 1'b0;
      indirect_index_o <= '0;
    end else begin
      indirect_go_o    <= indirect_req_i &&
                          hit_valid_reg[indirect_slot_i] &&
                          control_reg[`CTRL_ENABLE_BIT];
      indirect_index_o <= hit_index_reg[indirect_slot_i];
    end
  end

endmodule // search_engine_register_bank
`default_nettype wire

/* search_engine_register_bank_chk.sv */
// port assertions of the search engine register bank
`default_nettype none
`include "search_engine_consts.svh"
module search_engine_register_bank_chk (
  // clocks
  input wire logic                           clk_i,
  input wire logic                           reset_i,
  input wire logic                           phase_select_n_i,
  input wire logic                           core_clk_o,
  // axi4-lite
  input wire logic                           arvalid_i,
  input wire logic                           arready_o,
  input wire logic [`ADDR_WIDTH-1:0]         araddr_i,
  input wire logic                           rvalid_o,
  input wire logic                           rready_i,
  input wire logic [31:0]                    rdata_o,
  input wire logic [1:0]                     rresp_o,
  input wire logic                           bvalid_o,
  input wire logic                           bready_i,
  input wire logic [1:0]                     bresp_o,
  // datapath
  input wire search_engine_pkg::search_cmd_t search_i,
  input wire search_engine_pkg::array_wr_t   array_wr_i,
  input wire logic [`REG_WIDTH-1:0]          bit_match_o,
  input wire logic [`REG_WIDTH-1:0]          array_merged_o,
  input wire logic                           indirect_req_i,
  input wire logic                           indirect_go_o,
  input wire logic [`REG_WIDTH-1:0]          control_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  logic        core_edge;
  logic [67:0] same_k;
  logic [67:0] same_w;
  assign core_edge = !core_clk_o && phase_select_n_i;
  assign same_k = ~(search_i.key ^ search_i.entry);
  assign same_w = ~(array_wr_i.old_word ^ array_wr_i.new_word);
  property p_divide;
    !reset_i && phase_select_n_i |=> core_clk_o != $past(core_clk_o);
  endproperty
  a_divide: assert property (p_divide)
    else $error("core clock did not toggle");
  property p_align;
    !phase_select_n_i |=> !core_clk_o;
  endproperty
  a_align: assert property (p_align)
    else $error("core clock not realigned");
  property p_rd_lat;
    arvalid_i && arready_o |=> rvalid_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late");
  property p_rd_hold;
    rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o) && $stable(rresp_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read answer dropped");
  property p_ar_block;
    rvalid_o |-> !arready_o;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read taken while answer pending");
  property p_wr_hold;
    bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write response dropped");
  property p_slverr;
    arvalid_i && arready_o && araddr_i > 12'h104
      |=> rresp_o == `RESP_SLVERR && rdata_o == '0;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("unmapped read not refused");
  property p_go;
    indirect_go_o |-> $past(indirect_req_i) && $past(control_o[1]);
  endproperty
  a_go: assert property (p_go)
    else $error("indirect access without request");
  property p_match;
    core_edge && search_i.valid |=> (~bit_match_o & $past(same_k)) == '0;
  endproperty
  a_match: assert property (p_match)
    else $error("equal bit reported as mismatch");
  property p_merge;
    core_edge && array_wr_i.valid
      |=> ((array_merged_o ^ $past(array_wr_i.new_word)) & $past(same_w))
          == '0;
  endproperty
  a_merge: assert property (p_merge)
    else $error("merged word differs where old equals new");
  c_search: cover property (core_edge && search_i.valid);
  c_array: cover property (core_edge && array_wr_i.valid);
  c_go: cover property (indirect_go_o);
  c_err: cover property (rvalid_o && rresp_o == `RESP_SLVERR);
endmodule // search_engine_register_bank_chk

bind search_engine_register_bank search_engine_register_bank_chk i_chk (
  .clk_i, .reset_i, .phase_select_n_i, .core_clk_o, .arvalid_i, .arready_o,
  .araddr_i, .rvalid_o, .rready_i, .rdata_o, .rresp_o, .bvalid_o, .bready_i,
  .bresp_o, .search_i, .array_wr_i, .bit_match_o, .array_merged_o,
  .indirect_req_i, .indirect_go_o, .control_o);
`default_nettype wire

/* host_cmd_model.sv */
// host side model: two-cycle searches, results and masked array writes
`default_nettype none
module host_cmd_model (
  // clocks
  input  wire logic                          clk_i,
  input  wire logic                          core_clk_i,
  // commands
  output var search_engine_pkg::search_cmd_t search_o,
  output var search_engine_pkg::search_res_t result_o,
  output var search_engine_pkg::array_wr_t   array_wr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    search_o = '0;
    result_o = '0;
    array_wr_o = '0;
  end
  // returns after an edge whose successor is a core edge
  task automatic sync();
    @(posedge clk_i);
    while (core_clk_i !== 1'b1) @(posedge clk_i);
  endtask
  task automatic search(input logic [3:0] p, input logic [2:0] n,
                        input logic [67:0] ka, kb, e,
                        input search_engine_pkg::search_res_t r);
    sync();
    search_o <= {1'b1, 1'b0, p, n, ka, e};
    sync();
    search_o <= {1'b1, 1'b1, p, n, kb, e};
    result_o <= r;
    sync();
    search_o <= {1'b0, ~search_o[143:0]};
    result_o <= '0;
  endtask
  task automatic awrite(input logic [2:0] n, input logic h,
                        input logic [67:0] o, w);
    sync();
    array_wr_o <= {1'b1, n, h, o, w};
    sync();
    array_wr_o <= {1'b0, ~array_wr_o[139:0]};
  endtask
endmodule // host_cmd_model
`default_nettype wire

/* tb.sv */
// self-checking testbench of the search engine register bank
`default_nettype none
`include "search_engine_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, reset_i = 1, phase_select_n_i = 1;
  logic        awvalid_i = 0, wvalid_i = 0, arvalid_i = 0;
  logic        bready_i = 1, rready_i = 1, indirect_req_i = 0;
  logic [11:0] awaddr_i = '0, araddr_i = '0;
  logic [31:0] wdata_i = '0, d, lf = 32'h0000_0023;
  logic [2:0]  indirect_slot_i = '0, n, s;
  logic [3:0]  learn_pair_i = '0, p, p0, wstrb_i = 4'hf;
  logic [67:0] next_free_i = '0, v, ka, kb, e, m;
  logic [67:0] mask_m [16], comp_m [32], hit_m [8], ctrl_m, brd_m, bwr_m, nf_m;
  logic [13:0] ix;
  logic [1:0]  wd, r;
  logic        lw, gw;
  int          n_errors = 0, checked = 0, cyc = 0, ro [4];
  wire logic        core_clk_o, awready_o, wready_o, bvalid_o, arready_o;
  wire logic        rvalid_o, indirect_go_o;
  wire logic [1:0]  bresp_o, rresp_o;
  wire logic [31:0] rdata_o;
  wire logic [13:0] indirect_index_o;
  wire logic [67:0] bit_match_o, array_merged_o, learn_even_o, learn_odd_o;
  wire logic [67:0] control_o;
  wire search_engine_pkg::search_cmd_t search_i;
  wire search_engine_pkg::search_res_t result_i;
  wire search_engine_pkg::array_wr_t   array_wr_i;
  search_engine_register_bank i_search_engine_register_bank (
    .clk_i, .reset_i, .phase_select_n_i, .core_clk_o, .awvalid_i, .awready_o,
    .awaddr_i, .wvalid_i, .wready_o, .wdata_i, .wstrb_i, .bvalid_o,
    .bready_i, .bresp_o, .arvalid_i, .arready_o, .araddr_i, .rvalid_o,
    .rready_i, .rdata_o, .rresp_o, .search_i, .result_i, .bit_match_o,
    .array_wr_i, .array_merged_o, .learn_pair_i, .learn_even_o, .learn_odd_o,
    .indirect_req_i, .indirect_slot_i, .indirect_go_o, .indirect_index_o,
    .next_free_i, .control_o);
  host_cmd_model i_host (.clk_i, .core_clk_i(core_clk_o), .search_o(search_i),
    .result_o(result_i), .array_wr_o(array_wr_i));
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [67:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic void rnd(output logic [67:0] x);
    for (int i = 0; i < 3; i++) begin
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      x = {x[35:0], lf};
    end
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] dd);
    awaddr_i <= a;
    wdata_i <= dd;
    awvalid_i <= 1;
    wvalid_i <= 1;
    do begin
      @(posedge clk_i);
      if (awvalid_i && awready_o) awvalid_i <= 0;
      if (wvalid_i && wready_o) wvalid_i <= 0;
    end while (!(bvalid_o && bready_i));
    r = bresp_o;
  endtask
  task automatic rd(input logic [11:0] a);
    araddr_i <= a;
    arvalid_i <= 1;
    do begin
      @(posedge clk_i);
      if (arvalid_i && arready_o) arvalid_i <= 0;
    end while (!(rvalid_o && rready_i));
    d = rdata_o;
    r = rresp_o;
  endtask
  function automatic logic [67:0] mdl(input int i);
    if (i < 32) return comp_m[i];
    if (i < 48) return mask_m[i - 32];
    if (i < 56) return hit_m[i - 48];
    if (i == 56) return ctrl_m;
    if (i == 57) return `DEVICE_INFORMATION_DEFAULT;
    if (i == 58) return brd_m;
    if (i == 59) return bwr_m;
    if (i == 60) return nf_m;
    return '0;
  endfunction
  task automatic put(input int i, input logic [67:0] x);
    wr(12'h100, x[63:32]);
    wr(12'h104, {28'h0, x[67:64]});
    wr(12'(4 * i), x[31:0]);
    if (i >= 32 && i < 48) mask_m[i - 32] = x;
    if (i == 56) ctrl_m = x;
    if (i == 58) brd_m = x;
    if (i == 59) bwr_m = x;
  endtask
  task automatic ckm(input int i);
    logic [67:0] x;
    rd(12'(4 * i));
    x[31:0] = d;
    rd(12'h100);
    x[63:32] = d;
    rd(12'h104);
    x[67:64] = d[3:0];
    chk($sformatf("reg %0d", i), x, mdl(i));
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 0;
    rnd(nf_m);
    next_free_i <= nf_m;
    ctrl_m = `CONTROL_RESET;
    brd_m = '0;
    bwr_m = '0;
    for (int i = 0; i < 8; i++) hit_m[i] = '0;
    for (int i = 48; i < 61; i++) ckm(i);
    for (int i = 0; i < 8; i++) begin
      rnd(v);
      put(32 + 2 * i, v);
      put(33 + 2 * i, v);
    end
    for (int i = 32; i < 48; i++) ckm(i);
    rnd(v);
    put(58, v);
    wstrb_i <= 4'h1;
    wr(12'(4 * 58), ~v[31:0]);
    wstrb_i <= 4'hf;
    brd_m[7:0] = ~v[7:0];
    put(59, ~v);
    put(56, 68'h0_0000_0000_0000_0006);
    for (int i = 61; i < 64; i++) put(i, v);
    for (int i = 56; i < 64; i++) ckm(i);
    chk("control", control_o, ctrl_m);
    wr(12'h200, 32'h0000_0001);
    chk("bresp", r, `RESP_SLVERR);
    rd(12'h200);
    chk("rresp", r, `RESP_SLVERR);
    for (int k = 0; k < 4; k++) begin
      rnd(ka);
      rnd(kb);
      rnd(e);
      rnd(v);
      p = v[3:0];
      n = v[6:4];
      ix = v[20:7];
      if (k[0] == k[1]) s = v[23:21];
      if (k == 0) p0 = p;
      lw = k[0];
      gw = ~(k[0] ^ k[1]);
      wd = 2'(k == 0 ? 2 : (k == 1 ? 1 : 0));
      i_host.search(p, n, ka, kb, e, {1'b1, s, lw, gw, wd, ix});
      comp_m[2 * p] = ka;
      comp_m[2 * p + 1] = kb;
      if (lw | gw) hit_m[s][13:0] = ix & ~{12'h0, wd[1], |wd};
      if (gw) hit_m[s][31] = 1'b1;
      chk("match", bit_match_o, ~(kb ^ e) | ~mask_m[2 * n + 1]);
      ckm(2 * p);
      ckm(2 * p + 1);
      ckm(48 + s);
    end
    learn_pair_i <= p0;
    repeat (2) @(posedge clk_i);
    chk("learn even", learn_even_o, comp_m[2 * p0]);
    chk("learn odd", learn_odd_o, comp_m[2 * p0 + 1]);
    for (int i = 0; i < 8; i++) begin
      indirect_slot_i <= 3'(i);
      indirect_req_i <= 1;
      repeat (2) @(posedge clk_i);
      chk("go", indirect_go_o, hit_m[i][31]);
      chk("index", indirect_index_o, hit_m[i][13:0]);
    end
    indirect_slot_i <= s;
    put(56, '0);
    @(posedge clk_i);
    chk("go off", indirect_go_o, 0);
    indirect_req_i <= 0;
    for (int k = 0; k < 4; k++) begin
      rnd(ka);
      rnd(kb);
      rnd(v);
      i_host.awrite(v[2:0], v[3], ka, kb);
      m = mask_m[2 * v[2:0] + v[3]];
      chk("merge", array_merged_o, (kb & m) | (ka & ~m));
    end
    ro = '{2 * p0, 2 * p0 + 1, 48 + s, 57};
    for (int i = 0; i < 4; i++) begin
      rnd(v);
      put(ro[i], v);
      ckm(ro[i]);
    end
    phase_select_n_i <= 0;
    repeat (4) @(posedge clk_i);
    chk("core clock", core_clk_o, 0);
    phase_select_n_i <= 1;
    repeat (4) @(posedge clk_i);
    conclude();
  end
endmodule // tb
`default_nettype wire
